// File: dv/lirs_line_model.sv
// Model of the line terminal equipment that feeds the receive register bank.
// Assumes the bench hands it frame contents and a one-cycle go per interface.
`timescale 1ns/1ps
`default_nettype none
module lirs_line_model (
   // Clock and reset.
   input  wire logic                                         mclk,
   input  wire logic                                         rstn,
   // Commands from the bench.
   input  wire logic [lirs_pkg::NUM_IF-1:0]                  go,
   input  wire lirs_pkg::lirs_frame_s [lirs_pkg::NUM_IF-1:0] fr,
   input  wire lirs_pkg::lirs_line_s  [lirs_pkg::NUM_IF-1:0] ln,
   // Line side.
   output logic [lirs_pkg::NUM_IF-1:0]                       frame_pulse,
   output lirs_pkg::lirs_frame_s [lirs_pkg::NUM_IF-1:0]      frame_in,
   output lirs_pkg::lirs_line_s  [lirs_pkg::NUM_IF-1:0]      line_in,
   // Processing phase, high while a frame is taken in.
   output logic                                              processing_phase_flag
);
   // Frame data is valid only with its pulse; otherwise it shows the inverse.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         frame_pulse <= '0;
         frame_in    <= '1;
         processing_phase_flag <= 1'b0;
      end else begin
         frame_pulse <= go;
         processing_phase_flag <= |go;
         for (int i = 0; i < lirs_pkg::NUM_IF; i++) begin
            frame_in[i] <= go[i] ? fr[i] : ~fr[i];
         end
      end
   end

   // Event pulses ride with the frame pulse; frame bits are only valid then.
   always_comb begin
      for (int i = 0; i < lirs_pkg::NUM_IF; i++) begin
         line_in[i] = ln[i];
         if (!frame_pulse[i]) begin
            line_in[i].tx_slot_free = 1'b0;
            line_in[i].mf_complete  = 1'b0;
            line_in[i].mf_bits      = ~ln[i].mf_bits;
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/lirs_regs_bench.sv
// Self-checking bench for the receive status register bank.
// Assumes the line model is compiled before it.
`timescale 1ns/1ps
`default_nettype none
module lirs_regs_bench;
   logic                                         mclk, rstn, wr, rd, rd_q, slip_irq, ds, mk, up, chg;
   logic [7:0]                                   addr, wdata, rdata;
   logic                                         processing_phase_flag;
   logic [lirs_pkg::NUM_IF-1:0]                  go, frame_pulse, sv;
   lirs_pkg::lirs_frame_s [lirs_pkg::NUM_IF-1:0] fr, frame_in;
   lirs_pkg::lirs_line_s  [lirs_pkg::NUM_IF-1:0] ln, line_in;
   logic [7:0]                                   q[$];
   int                                           errors, n_tests, cyc;

   lirs_regs uut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .frame_pulse(frame_pulse), .frame_in(frame_in), .line_in(line_in),
      .processing_phase_flag(processing_phase_flag), .slip_irq(slip_irq));
   lirs_line_model far (.mclk(mclk), .rstn(rstn), .go(go), .fr(fr), .ln(ln), .frame_pulse(frame_pulse),
      .frame_in(frame_in), .line_in(line_in), .processing_phase_flag(processing_phase_flag));

   // Clock of 10 ns.
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Compares one value and counts it.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask

   // One bus cycle, launched just after a rising edge.
   task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr    <= w;
      rd    <= r;
      addr  <= a;
      wdata <= d;
   endtask

   // A read whose expected byte is queued for the watcher.
   task automatic rx(input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, 1'b1, a, 8'h00);
      q.push_back(e);
   endtask

   // Expected D or E receive byte from the frame sent.
   function automatic logic [7:0] dex(input logic [1:0] ch, input lirs_pkg::lirs_frame_s f);
      return {ch, ds ? 1'b1 : f.mf_bit, ds ? f.mf_bit : 1'b1, {3{f.rx_valid}}, f.s_bit};
   endfunction

   task automatic summarize;
      if (errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Reset with quiet line levels.
   task automatic reset_all;
      @(posedge mclk);
      ln   <= '0;
      sv   = '0;
      rstn <= 1'b0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
   endtask

   // Watcher: read data stands only in the cycle after the strobe; also the timeout.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (rd_q) check(rdata, q.pop_front());
      rd_q <= rd;
      if (cyc == 5000) begin
         errors++;
         summarize();
      end
   end

   // Main sequence: S/T mode pass, then Up mode pass, each after a reset.
   initial begin
      {rstn, wr, rd, go, fr, ln, addr, wdata} = '0;
      {errors, n_tests} = '0;
      void'($urandom(32'h9CF27807));
      for (int m = 0; m < 2; m++) begin
         reset_all();
         rx(lirs_pkg::ADDR_LINE_STATUS, lirs_pkg::RST_STATUS);
         rx(lirs_pkg::ADDR_SYNC_OVIEW, 8'h00);
         rx(8'h00, 8'h00);
         for (int i = 0; i < lirs_pkg::NUM_IF; i++) begin
            ds = 1'($urandom);
            mk = 1'($urandom);
            up = m[0];
            acc(1'b1, 1'b0, lirs_pkg::ADDR_IF_SEL, 8'(i));
            acc(1'b1, 1'b0, lirs_pkg::ADDR_CTRL, {5'h00, up, mk, ds});
            acc(1'b0, 1'b0, 8'h00, 8'h00);
            fr[i] <= 24'($urandom);
            ln[i] <= 11'($urandom) | 11'h030;
            go    <= 4'(1 << i);
            acc(1'b0, 1'b0, 8'h00, 8'h00);
            go    <= '0;
            repeat (3) @(posedge mclk);
            #1;
            chg   = ln[i].sync_src != sv[i];
            sv[i] = ln[i].sync_src;
            check({7'h00, slip_irq}, {7'h00, chg & mk});
            if (up) begin
               rx(lirs_pkg::ADDR_D_RX, dex(fr[i].d, fr[i]));
               rx(lirs_pkg::ADDR_E_RX, dex(fr[i].e, fr[i]));
               rx(lirs_pkg::ADDR_MF_RECEIVE, {1'b1, fr[i].s_bit, 2'b01, ln[i].mf_bits});
               rx(lirs_pkg::ADDR_MF_RECEIVE, {1'b1, fr[i].s_bit, 2'b00, ln[i].mf_bits});
               acc(1'b1, 1'b0, lirs_pkg::ADDR_MF_TRANSMIT, 8'($urandom));
               rx(lirs_pkg::ADDR_MF_RECEIVE, {1'b0, fr[i].s_bit, 2'b00, ln[i].mf_bits});
            end
            rx(lirs_pkg::ADDR_B1_RX, fr[i].active ? fr[i].b1 : lirs_pkg::IDLE_BYTE);
            rx(lirs_pkg::ADDR_B2_RX, fr[i].active ? fr[i].b2 : lirs_pkg::IDLE_BYTE);
            rx(lirs_pkg::ADDR_LINE_STATUS, up ? {sv[i], 7'h00} : {sv[i], 3'h0, ln[i].dch_busy,
               ln[i].contention, ln[i].lprio_class, ln[i].hprio_class});
            rx(lirs_pkg::ADDR_SYNC_OVIEW, {4'h0, sv});
            rx(lirs_pkg::ADDR_MF_FLAG, {7'h00, fr[i].rx_valid});
            rx(lirs_pkg::ADDR_IF_SEL, 8'(i));
            rx(lirs_pkg::ADDR_CTRL, {5'h00, up, mk, ds});
            acc(1'b0, 1'b0, 8'h00, 8'h00);
            repeat (2) @(posedge mclk);
            #1;
            check({7'h00, slip_irq}, 8'h00);
         end
      end
      repeat (2) @(posedge mclk);
      summarize();
   end
endmodule
`default_nettype wire

// File: rtl/lirs_pkg.sv
// Package for the line interface receive status register bank.
// Assumes a byte-wide register port and four line interfaces.
package lirs_pkg;
   // Interface count and register offsets.
   localparam int          NUM_IF            = 4;
   localparam logic [7:0]  ADDR_IF_SEL       = 8'h4C;
   localparam logic [7:0]  ADDR_SYNC_OVIEW   = 8'h13;
   localparam logic [7:0]  ADDR_LINE_STATUS  = 8'h2F;
   localparam logic [7:0]  ADDR_MF_TRANSMIT  = 8'h33;
   localparam logic [7:0]  ADDR_MF_RECEIVE   = 8'h34;
   localparam logic [7:0]  ADDR_MF_FLAG      = 8'h35;
   localparam logic [7:0]  ADDR_B1_RX        = 8'h3C;
   localparam logic [7:0]  ADDR_B2_RX        = 8'h3D;
   localparam logic [7:0]  ADDR_D_RX         = 8'h3E;
   localparam logic [7:0]  ADDR_E_RX         = 8'h3F;
   localparam logic [7:0]  ADDR_CTRL         = 8'h36;
   // Field positions.
   localparam int          POS_TX_RDY        = 7;
   localparam int          POS_UP_S          = 6;
   localparam int          POS_RX_RDY        = 4;
   localparam int          POS_HPRIO         = 0;
   localparam int          POS_LPRIO         = 1;
   localparam int          POS_CONT          = 2;
   localparam int          POS_ACT           = 3;
   localparam int          POS_SYNC_SRC      = 7;
   localparam int          POS_DEST_SEL      = 0;
   localparam int          POS_SLIP_MASK     = 1;
   localparam int          POS_UP_MODE       = 2;
   // Reset and idle values.
   localparam logic [7:0]  RST_STATUS        = 8'h00;
   localparam logic [7:0]  IDLE_BYTE         = 8'hFF;
   localparam logic [7:0]  RST_CTRL          = 8'h00;

   // Per-frame received sample from one line interface.
   typedef struct packed {
      logic [7:0] b1;
      logic [7:0] b2;
      logic [1:0] d;
      logic [1:0] e;
      logic       s_bit;
      logic       mf_bit;
      logic       rx_valid;
      logic       active;
   } lirs_frame_s;

   // Line-side status of one line interface.
   typedef struct packed {
      logic       hprio_class;
      logic       lprio_class;
      logic       contention;
      logic       dch_busy;
      logic       sync_src;
      logic       tx_slot_free;
      logic       mf_complete;
      logic [3:0] mf_bits;
   } lirs_line_s;
endpackage

// File: rtl/lirs_regs.sv
// Receive status and data registers of the line interfaces, one copy per interface.
// Assumes line-side inputs synchronous to mclk and a master that never waits.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Set tx-ready when free; a write to the transmit register clears it for the selected interface.
// - Up S-bit held, mirrored in D/E.
// - High priority class: 0=8, 1=9 ones.
// - Low priority class: 0=10, 1=11 ones.
// - Bit 2 flags D/E contention last frame, in S/T only.
// - Bit 3 high while D-channel transmits, in S/T only.
// - Priority bits meaningful in S/T only.
// - Bit 7 shows frame sync source used.
// - Sync source change raises masked interrupt.
// - Sync source bits collected in overview.
// - B1/B2 give byte; 0xFF when deactivated.
// - Data updated at each frame pulse.
// - D/E bits 3..1 return rx-valid.
// - Bit 4 carries S/Q when select 1.
// - Bit 5 carries S/Q when select 0.
// - A/B, S/G equal in D and E.
// - Rx-ready set on multiframe, cleared on read.
module lirs_regs (
   // Clock and reset.
   input  wire logic                                  mclk,
   input  wire logic                                  rstn,
   // Register port.
   input  wire logic [7:0]                            addr,
   input  wire logic [7:0]                            wdata,
   input  wire logic                                  wr,
   input  wire logic                                  rd,
   output logic      [7:0]                            rdata,
   // Line side, one entry per interface.
   input  wire logic [lirs_pkg::NUM_IF-1:0]           frame_pulse,
   input  wire lirs_pkg::lirs_frame_s [lirs_pkg::NUM_IF-1:0] frame_in,
   input  wire lirs_pkg::lirs_line_s  [lirs_pkg::NUM_IF-1:0] line_in,
   // Frame processing phase and slip interrupt.
   input  wire logic                                  processing_phase_flag,
   output logic                                       slip_irq
);
   localparam int N = lirs_pkg::NUM_IF;

   // Selector and control register.
   logic [1:0]  sel_q;
   logic [7:0]  ctrl_q;
   logic        slip_pend_q;
   logic [7:0]  rdata_q;

   // Per-interface state.
   lirs_pkg::lirs_frame_s frame_q [N];
   logic [N-1:0] tx_rdy_q;
   logic [N-1:0] rx_rdy_q;
   logic [N-1:0] sync_src_q;
   logic [3:0]   mf_q [N];
   logic [7:0]   stat_q [N];

   // Decoded strobes.
   wire         wr_sel   = wr && (addr == lirs_pkg::ADDR_IF_SEL);
   wire         wr_ctrl  = wr && (addr == lirs_pkg::ADDR_CTRL);
   wire         wr_mftx  = wr && (addr == lirs_pkg::ADDR_MF_TRANSMIT);
   wire         rd_mfrx  = rd && (addr == lirs_pkg::ADDR_MF_RECEIVE);
   wire         dest_sel = ctrl_q[lirs_pkg::POS_DEST_SEL];
   wire         up_mode  = ctrl_q[lirs_pkg::POS_UP_MODE];
   wire [N-1:0] sync_chg;

   // Per-interface registers.
   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_if
         wire sel_me = (sel_q == 2'(gi));
         assign sync_chg[gi] = (line_in[gi].sync_src != sync_src_q[gi]);
         // Frame data captured on the frame pulse only.
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               frame_q[gi] <= '0;
               mf_q[gi]    <= 4'h0;
            end else if (frame_pulse[gi]) begin
               frame_q[gi] <= frame_in[gi];
               mf_q[gi]    <= line_in[gi].mf_bits;
            end
         end
         // Status, flags and sync source.
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               tx_rdy_q[gi]   <= 1'b0;
               rx_rdy_q[gi]   <= 1'b0;
               sync_src_q[gi] <= 1'b0;
               stat_q[gi]     <= lirs_pkg::RST_STATUS;
            end else begin
               // Set wins over clear for both flags.
               if (line_in[gi].tx_slot_free) begin
                  tx_rdy_q[gi] <= 1'b1;
               end else if (wr_mftx && sel_me) begin
                  tx_rdy_q[gi] <= 1'b0;
               end
               if (line_in[gi].mf_complete) begin
                  rx_rdy_q[gi] <= 1'b1;
               end else if (rd_mfrx && sel_me) begin
                  rx_rdy_q[gi] <= 1'b0;
               end
               sync_src_q[gi] <= line_in[gi].sync_src;
               // Priority, contention and activity bits live in S/T mode only.
               stat_q[gi] <= up_mode ? 8'h00 : {4'h0, line_in[gi].dch_busy, line_in[gi].contention,
                             line_in[gi].lprio_class, line_in[gi].hprio_class};
            end
         end
      end
   endgenerate

   // Selector, control and slip interrupt.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sel_q       <= 2'h0;
         ctrl_q      <= lirs_pkg::RST_CTRL;
         slip_pend_q <= 1'b0;
      end else begin
         if (wr_sel) begin
            sel_q <= wdata[1:0];
         end
         if (wr_ctrl) begin
            ctrl_q <= wdata;
         end
         if (|sync_chg) begin
            slip_pend_q <= 1'b1;
         end else if (rd && addr == lirs_pkg::ADDR_SYNC_OVIEW) begin
            slip_pend_q <= 1'b0;
         end
      end
   end

   assign slip_irq = slip_pend_q && ctrl_q[lirs_pkg::POS_SLIP_MASK];

   // Read data for the selected interface.
   lirs_pkg::lirs_frame_s fs;
   logic [7:0] de_low;
   logic       ab_bit;
   logic       sg_bit;
   logic [7:0] rd_d;
   assign fs     = frame_q[sel_q];
   assign ab_bit = dest_sel ? fs.mf_bit : 1'b1;
   assign sg_bit = dest_sel ? 1'b1 : fs.mf_bit;
   assign de_low = {2'b00, sg_bit, ab_bit, {3{fs.rx_valid}}, fs.s_bit};

   always_comb begin
      case (addr)
         lirs_pkg::ADDR_IF_SEL:      rd_d = {6'h00, sel_q};
         lirs_pkg::ADDR_CTRL:        rd_d = ctrl_q;
         lirs_pkg::ADDR_SYNC_OVIEW:  rd_d = {4'h0, sync_src_q};
         lirs_pkg::ADDR_LINE_STATUS: rd_d = stat_q[sel_q] | {sync_src_q[sel_q], 7'h00};
         lirs_pkg::ADDR_MF_RECEIVE:  rd_d = {tx_rdy_q[sel_q], fs.s_bit, 1'b0, rx_rdy_q[sel_q], mf_q[sel_q]};
         lirs_pkg::ADDR_MF_FLAG:     rd_d = {7'h00, fs.rx_valid};
         lirs_pkg::ADDR_B1_RX:       rd_d = fs.active ? fs.b1 : lirs_pkg::IDLE_BYTE;
         lirs_pkg::ADDR_B2_RX:       rd_d = fs.active ? fs.b2 : lirs_pkg::IDLE_BYTE;
         lirs_pkg::ADDR_D_RX:        rd_d = {fs.d, 6'h00} | de_low;
         lirs_pkg::ADDR_E_RX:        rd_d = {fs.e, 6'h00} | de_low;
         default:                    rd_d = 8'h00;
      endcase
   end

   // Read data registered one cycle after the strobe.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd ? rd_d : 8'h00;
      end
   end
   assign rdata = rdata_q;

   // Checks.
   // A write to the transmit register clears tx ready of the selected interface.
   property p_tx_rdy_clear;
      @(posedge mclk) disable iff (!rstn)
      (wr_mftx && !line_in[sel_q].tx_slot_free) |=> !tx_rdy_q[$past(sel_q)];
   endproperty
   a_tx_rdy_clear: assert property (p_tx_rdy_clear) else $error("tx ready not cleared");

   // Rx ready rises with a completed multiframe.
   property p_rx_rdy_set;
      @(posedge mclk) disable iff (!rstn)
      line_in[0].mf_complete |=> rx_rdy_q[0];
   endproperty
   a_rx_rdy_set: assert property (p_rx_rdy_set) else $error("rx ready not set");

   // A deactivated interface reads all ones on B1.
   property p_idle_b1;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_B1_RX && !fs.active) |=> rdata == 8'hFF;
   endproperty
   a_idle_b1: assert property (p_idle_b1) else $error("idle B1 not FF");

   // Spare D bits 3 to 1 repeat the rx-valid flag.
   property p_rx_valid_bits;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_D_RX) |=> rdata[3:1] == {3{$past(fs.rx_valid)}};
   endproperty
   a_rx_valid_bits: assert property (p_rx_valid_bits) else $error("D bits 3..1 wrong");

   // A/B reads one when the destination select is clear.
   property p_ab_const;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_E_RX && !dest_sel) |=> rdata[4];
   endproperty
   a_ab_const: assert property (p_ab_const) else $error("A/B not 1");

   // S/G reads one when the destination select is set.
   property p_sg_const;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_D_RX && dest_sel) |=> rdata[5];
   endproperty
   a_sg_const: assert property (p_sg_const) else $error("S/G not 1");

   // Frame data holds between frame pulses.
   property p_frame_hold;
      @(posedge mclk) disable iff (!rstn)
      !frame_pulse[0] |=> frame_q[0] == $past(frame_q[0]);
   endproperty
   a_frame_hold: assert property (p_frame_hold) else $error("frame data moved");

   // A sync source change raises the unmasked interrupt.
   property p_slip;
      @(posedge mclk) disable iff (!rstn)
      (sync_chg[0] && ctrl_q[lirs_pkg::POS_SLIP_MASK] && !wr_ctrl) |=> slip_irq;
   endproperty
   a_slip: assert property (p_slip) else $error("slip irq missing");

   // Status bits 3 to 0 stay clear in Up mode.
   property p_st_only;
      @(posedge mclk) disable iff (!rstn)
      ($past(up_mode) && up_mode) |-> stat_q[0] == 8'h00;
   endproperty
   a_st_only: assert property (p_st_only) else $error("S/T bits in Up mode");

   // Tx ready rises with a free transmit slot.
   property p_tx_rdy_set;
      @(posedge mclk) disable iff (!rstn)
      line_in[0].tx_slot_free |=> tx_rdy_q[0];
   endproperty
   a_tx_rdy_set: assert property (p_tx_rdy_set) else $error("tx ready not set");

   // Reading the receive register clears rx ready of the selected interface.
   property p_rx_rdy_clear;
      @(posedge mclk) disable iff (!rstn)
      (rd_mfrx && !line_in[sel_q].mf_complete) |=> !rx_rdy_q[$past(sel_q)];
   endproperty
   a_rx_rdy_clear: assert property (p_rx_rdy_clear) else $error("rx ready not cleared");

   // The multiframe register shows the last S-bit in bit 6.
   property p_mf_s_bit;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_MF_RECEIVE) |=> rdata[lirs_pkg::POS_UP_S] == $past(fs.s_bit);
   endproperty
   a_mf_s_bit: assert property (p_mf_s_bit) else $error("multiframe S-bit wrong");

   // D and E registers mirror the S-bit in bit 0.
   property p_de_s_bit;
      @(posedge mclk) disable iff (!rstn)
      (rd && (addr == lirs_pkg::ADDR_D_RX || addr == lirs_pkg::ADDR_E_RX)) |=> rdata[0] == $past(fs.s_bit);
   endproperty
   a_de_s_bit: assert property (p_de_s_bit) else $error("D/E S-bit wrong");

   // High priority class follows the line in S/T mode.
   property p_hprio;
      @(posedge mclk) disable iff (!rstn)
      (!up_mode && line_in[0].hprio_class) |=> stat_q[0][lirs_pkg::POS_HPRIO];
   endproperty
   a_hprio: assert property (p_hprio) else $error("high priority class lost");

   // Low priority class follows the line in S/T mode.
   property p_lprio;
      @(posedge mclk) disable iff (!rstn)
      (!up_mode && line_in[0].lprio_class) |=> stat_q[0][lirs_pkg::POS_LPRIO];
   endproperty
   a_lprio: assert property (p_lprio) else $error("low priority class lost");

   // Contention is reported in S/T mode.
   property p_cont;
      @(posedge mclk) disable iff (!rstn)
      (!up_mode && line_in[0].contention) |=> stat_q[0][lirs_pkg::POS_CONT];
   endproperty
   a_cont: assert property (p_cont) else $error("contention lost");

   // D-channel activity is reported in S/T mode.
   property p_act;
      @(posedge mclk) disable iff (!rstn)
      (!up_mode && line_in[0].dch_busy) |=> stat_q[0][lirs_pkg::POS_ACT];
   endproperty
   a_act: assert property (p_act) else $error("D-channel activity lost");

   // Bits 6 to 4 of the line status always read zero.
   property p_stat_upper;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_LINE_STATUS) |=> rdata[6:4] == 3'h0;
   endproperty
   a_stat_upper: assert property (p_stat_upper) else $error("status spare bits set");

   // Line status bit 7 shows the sync source of the selected interface.
   property p_stat_sync;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_LINE_STATUS) |=> rdata[lirs_pkg::POS_SYNC_SRC] == $past(sync_src_q[sel_q]);
   endproperty
   a_stat_sync: assert property (p_stat_sync) else $error("status sync source wrong");

   // The sync source copy follows the line.
   property p_sync_follow;
      @(posedge mclk) disable iff (!rstn)
      line_in[0].sync_src |=> sync_src_q[0];
   endproperty
   a_sync_follow: assert property (p_sync_follow) else $error("sync source not taken");

   // A cleared mask keeps the interrupt low.
   property p_slip_masked;
      @(posedge mclk) disable iff (!rstn)
      !ctrl_q[lirs_pkg::POS_SLIP_MASK] |-> !slip_irq;
   endproperty
   a_slip_masked: assert property (p_slip_masked) else $error("masked slip irq high");

   // The overview collects the sync sources of all interfaces.
   property p_oview;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_SYNC_OVIEW) |=> rdata == {4'h0, $past(sync_src_q)};
   endproperty
   a_oview: assert property (p_oview) else $error("overview wrong");

   // A deactivated interface reads all ones on B2.
   property p_idle_b2;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_B2_RX && !fs.active) |=> rdata == lirs_pkg::IDLE_BYTE;
   endproperty
   a_idle_b2: assert property (p_idle_b2) else $error("idle B2 not FF");

   // An active interface returns its B1 byte.
   property p_active_b1;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_B1_RX && fs.active) |=> rdata == $past(fs.b1);
   endproperty
   a_active_b1: assert property (p_active_b1) else $error("B1 byte wrong");

   // Selected receive data holds through the non-processing phase.
   property p_nonproc_stable;
      @(posedge mclk) disable iff (!rstn)
      (!processing_phase_flag && !wr_sel) |=> $stable(fs);
   endproperty
   a_nonproc_stable: assert property (p_nonproc_stable) else $error("data moved outside processing");

   // Spare E bits 3 to 1 repeat the rx-valid flag.
   property p_rx_valid_e;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_E_RX) |=> rdata[3:1] == {3{$past(fs.rx_valid)}};
   endproperty
   a_rx_valid_e: assert property (p_rx_valid_e) else $error("E bits 3..1 wrong");

   // A/B carries the multiframe bit when the select is set.
   property p_ab_carry;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_D_RX && dest_sel) |=> rdata[4] == $past(fs.mf_bit);
   endproperty
   a_ab_carry: assert property (p_ab_carry) else $error("A/B bit wrong");

   // S/G carries the multiframe bit when the select is clear.
   property p_sg_carry;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_E_RX && !dest_sel) |=> rdata[5] == $past(fs.mf_bit);
   endproperty
   a_sg_carry: assert property (p_sg_carry) else $error("S/G bit wrong");

   // The D register carries the two D-channel bits on top.
   property p_d_bits;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_D_RX) |=> rdata[7:6] == $past(fs.d);
   endproperty
   a_d_bits: assert property (p_d_bits) else $error("D bits wrong");

   // The E register carries the two echo bits on top.
   property p_e_bits;
      @(posedge mclk) disable iff (!rstn)
      (rd && addr == lirs_pkg::ADDR_E_RX) |=> rdata[7:6] == $past(fs.e);
   endproperty
   a_e_bits: assert property (p_e_bits) else $error("E bits wrong");

   // Read data is zero outside the cycle after a read.
   property p_rdata_idle;
      @(posedge mclk) disable iff (!rstn)
      !rd |=> rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule
`default_nettype wire
